//--- verif/dcsr_board.sv
// Board logic around the shift register: drives mode, both clocks and data.
// Assumes the caller syncs on i_clk; the left-shift wiring is chosen by i_left_wire.
`timescale 1ns/1ps
module dcsr_board (
   input wire logic i_clk,
   input wire logic i_left_wire,
   input wire logic [dcsr_pkg::DCSR_WIDTH-1:0] i_reg_out,
   output logic o_mode_sel,
   output logic o_shift_clock_n,
   output logic o_load_clock_n,
   output logic o_serial_in,
   output logic [dcsr_pkg::DCSR_WIDTH-1:0] o_parallel_in
);
   import dcsr_pkg::*;
   logic [DCSR_WIDTH-1:0] par_q;

   // Left shift feeds outputs 3..1 back into parallel inputs 2..0
   assign o_parallel_in = i_left_wire ? {par_q[3], i_reg_out[3:1]} : par_q;

   initial begin
      o_mode_sel = 1'b0;
      o_shift_clock_n = 1'b0;
      o_load_clock_n = 1'b0;
      o_serial_in = 1'b0;
      par_q = 4'h0;
   end

   // Set mode and data, then leave them settled for a few cycles
   task automatic put(input logic m, input logic s, input logic [3:0] p);
      @(posedge i_clk);
      o_mode_sel <= m;
      o_serial_in <= s;
      par_q <= p;
      repeat (3) @(posedge i_clk);
   endtask

   // Move one clock pin to a level and hold it past the pulse width
   task automatic edge_to(input logic ld, input logic lvl);
      @(posedge i_clk);
      if (ld) begin
         o_load_clock_n <= lvl;
      end else begin
         o_shift_clock_n <= lvl;
      end
      repeat (4) @(posedge i_clk);
   endtask
endmodule

//--- verif/tb.sv
// Self-checking bench for the dual-clock shift register and its stream FIFO.
// Assumes the board model drives every pin; expectations come from a model here.
`timescale 1ns/1ps
module tb;
   import dcsr_pkg::*;
   logic clk, i_reset, ready, hold_q, left_q, mode, sck, lck, ser;
   logic upd, ovf, sval, mload;
   logic [3:0] par, rout, sdata, exp_reg, ovf_cnt;
   logic [3:0] exp_q[$];
   logic [3:0] st_q[$];
   int seed = 32'he1e3;
   int err_total = 0;
   int comparisons = 0;

   dcsr_top dut (.i_clk(clk), .i_reset(i_reset), .i_mode_sel(mode), .i_shift_clock_n(sck),
      .i_load_clock_n(lck), .i_serial_in(ser), .i_parallel_in(par), .o_reg_out(rout),
      .o_mode_load(mload), .o_update(upd), .o_overflow(ovf), .o_stream_valid(sval),
      .i_stream_ready(ready), .o_stream_data(sdata));
   dcsr_board board (.i_clk(clk), .i_left_wire(left_q), .i_reg_out(rout), .o_mode_sel(mode),
      .o_shift_clock_n(sck), .o_load_clock_n(lck), .o_serial_in(ser), .o_parallel_in(par));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic check(input logic [3:0] seen, input logic [3:0] want);
      comparisons++;
      if (seen !== want) begin
         err_total++;
         $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask

   task automatic stop_test;
      $display("comparisons=%0d err_total=%0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // One clock pulse; mode may change while the clock is high
   task automatic step(input logic m0, input logic m1, input logic ld);
      logic s;
      logic [3:0] p;
      logic [3:0] e;
      s = 1'($random(seed));
      p = 4'($random(seed));
      board.put(m0, s, p);
      board.edge_to(ld, 1'b1);
      board.put(m1, s, p);
      check({3'h0, mload}, {3'h0, m1});
      e = left_q ? {p[3], exp_reg[3:1]} : p;
      if (m1 == ld) begin
         exp_reg = ld ? e : {exp_reg[2:0], s};
         exp_q.push_back(exp_reg);
      end
      board.edge_to(ld, 1'b0);
   endtask

   // Random drain of the stream unless a fill is under way
   always @(posedge clk) begin
      ready <= hold_q ? 1'b0 : 1'($random(seed));
   end

   // Each update takes the oldest expectation; each read takes the oldest word
   always @(posedge clk) begin
      if (!i_reset && upd) begin
         if (exp_q.size() == 0) begin
            check(rout, 4'hx);
         end else begin
            st_q.push_back(exp_q[0]);
            check(rout, exp_q.pop_front());
         end
      end
      if (!i_reset && ovf) begin
         void'(st_q.pop_back());
         ovf_cnt <= ovf_cnt + 4'h1;
      end
      if (!i_reset && sval && ready) begin
         check(sdata, st_q.size() > 0 ? st_q.pop_front() : 4'hx);
      end
   end

   initial begin
      repeat (8000) @(posedge clk);
      err_total++;
      stop_test;
   end

   initial begin
      i_reset = 1'b1;
      hold_q = 1'b0;
      left_q = 1'b0;
      ovf_cnt = 4'h0;
      exp_reg = DCSR_REG_RESET;
      repeat (2) @(posedge clk);
      i_reset <= 1'b0;
      @(posedge clk);
      check(rout, DCSR_REG_RESET);
      for (int i = 0; i < 8; i++) step(1'b0, 1'b0, 1'b0);
      $display("test shift done");
      step(1'b1, 1'b1, 1'b0);
      step(1'b0, 1'b0, 1'b1);
      $display("test unselected clock done");
      step(1'b0, 1'b1, 1'b1);
      step(1'b1, 1'b0, 1'b0);
      $display("test mode change done");
      left_q = 1'b1;
      for (int i = 0; i < 4; i++) step(1'b1, 1'b1, 1'b1);
      left_q = 1'b0;
      $display("test left shift done");
      repeat (100) @(posedge clk);
      hold_q <= 1'b1;
      for (int i = 0; i < 20; i++) step(1'b1, 1'b1, 1'b1);
      repeat (4) @(posedge clk);
      check(ovf_cnt, 4'h3);
      hold_q <= 1'b0;
      repeat (300) @(posedge clk);
      check(4'(exp_q.size()), 4'h0);
      check(4'(st_q.size()), 4'h0);
      $display("test fill and drain done");
      stop_test;
   end
endmodule

//--- verilog/dcsr_fifo.sv
// Small synchronous FIFO with valid/ready on both sides and registered read data.
// Assumes one clock and a synchronous active-high reset; holds DEPTH+1 words.
`timescale 1ns/1ps
module dcsr_fifo #(
   parameter int WIDTH = 4,
   parameter int DEPTH = 16
) (
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_wr_valid,
   output logic o_wr_ready,
   input wire logic [WIDTH-1:0] i_wr_data,
   output logic o_rd_valid,
   input wire logic i_rd_ready,
   output logic [WIDTH-1:0] o_rd_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wptr_q;
   logic [AW-1:0] rptr_q;
   logic [AW:0] count_q;
   logic out_valid_q;
   logic [WIDTH-1:0] out_data_q;
   logic push;
   logic pop;

   // Accept while the array has room; pop into the output stage when it frees
   assign o_wr_ready = (count_q != (AW+1)'(DEPTH));
   assign push = i_wr_valid && o_wr_ready;
   assign pop = (count_q != '0) && (!out_valid_q || i_rd_ready);
   assign o_rd_valid = out_valid_q;
   assign o_rd_data = out_data_q;

   // Storage array
   always_ff @(posedge i_clk) begin
      if (push) begin
         mem_q[wptr_q] <= i_wr_data;
      end
   end

   // Pointers and fill level
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         wptr_q <= '0;
         rptr_q <= '0;
         count_q <= '0;
      end else begin
         if (push) begin
            wptr_q <= wptr_q + 1'b1;
         end
         if (pop) begin
            rptr_q <= rptr_q + 1'b1;
         end
         count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   // Registered output stage
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         out_valid_q <= 1'b0;
         out_data_q <= '0;
      end else if (pop) begin
         out_valid_q <= 1'b1;
         out_data_q <= mem_q[rptr_q];
      end else if (i_rd_ready) begin
         out_valid_q <= 1'b0;
      end
   end

endmodule

//--- verilog/dcsr_pkg.sv
// Constants and types shared by the dual-clock 4-bit shift register block.
// Assumes a single 200 MHz system clock; all pin inputs are asynchronous.
package dcsr_pkg;

   // Register width and stream FIFO depth
   localparam int DCSR_WIDTH = 4;
   localparam int DCSR_FIFO_DEPTH = 16;

   // Pin capture vector layout: {mode, shift clock, load clock, serial, parallel[3:0]}
   localparam int DCSR_PIN_COUNT = 8;
   localparam int DCSR_PIN_PAR_LSB = 0;
   localparam int DCSR_PIN_SERIAL = 4;
   localparam int DCSR_PIN_LOAD_CLK = 5;
   localparam int DCSR_PIN_SHIFT_CLK = 6;
   localparam int DCSR_PIN_MODE = 7;

   // Reset values
   localparam logic [DCSR_WIDTH-1:0] DCSR_REG_RESET = 4'h0;
   localparam logic [DCSR_PIN_COUNT-1:0] DCSR_SYNC_RESET = 8'h00;

   // Effective mode, one-hot
   typedef enum logic [1:0] {
      DCSR_MODE_SHIFT = 2'b01,
      DCSR_MODE_LOAD = 2'b10
   } dcsr_mode_type;

endpackage

//--- verilog/dcsr_top.sv
// Dual-clock 4-bit shift register: right shift on the shift clock, parallel
// load on the load clock, the mode select picking which clock counts.
// Assumes all pins are asynchronous to i_clk and that pin pulses last well
// over three i_clk periods; every new register value is offered to a FIFO, which drops it when full.
// Functional notes
// - Mode select low picks shift, high load
// - Update only on falling edge of enabled clock
// - Load falling edge copies parallel inputs
// - Shift falling edge moves serial into bit0 upward
// - Mode changes alone never alter o_reg_out
`timescale 1ns/1ps
module dcsr_top (
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_mode_sel,
   input wire logic i_shift_clock_n,
   input wire logic i_load_clock_n,
   input wire logic i_serial_in,
   input wire logic [dcsr_pkg::DCSR_WIDTH-1:0] i_parallel_in,
   output logic [dcsr_pkg::DCSR_WIDTH-1:0] o_reg_out,
   output logic o_mode_load,
   output logic o_update,
   output logic o_overflow,
   output logic o_stream_valid,
   input wire logic i_stream_ready,
   output logic [dcsr_pkg::DCSR_WIDTH-1:0] o_stream_data
);
   import dcsr_pkg::*;

   logic [DCSR_PIN_COUNT-1:0] pins;
   logic [DCSR_PIN_COUNT-1:0] sync1_q;
   logic [DCSR_PIN_COUNT-1:0] sync2_q;
   logic shift_clk_prev_q;
   logic load_clk_prev_q;
   logic mode_s;
   logic serial_s;
   logic [DCSR_WIDTH-1:0] par_s;
   logic shift_fall;
   logic load_fall;
   dcsr_mode_type mode_eff;
   logic upd;
   logic [DCSR_WIDTH-1:0] reg_q;
   logic [DCSR_WIDTH-1:0] reg_d;
   logic upd_q;
   logic ovf_q;
   logic fifo_ready;

   // Gather all pins into one vector for the synchroniser
   assign pins = {i_mode_sel, i_shift_clock_n, i_load_clock_n, i_serial_in, i_parallel_in};

   // Two-stage synchroniser; only the second stage is read by logic
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         sync1_q <= DCSR_SYNC_RESET;
         sync2_q <= DCSR_SYNC_RESET;
      end else begin
         sync1_q <= pins;
         sync2_q <= sync1_q;
      end
   end

   // Synchronised views of mode and data, taken from the second stage only
   assign mode_s = sync2_q[DCSR_PIN_MODE];
   assign serial_s = sync2_q[DCSR_PIN_SERIAL];
   assign par_s = sync2_q[DCSR_PIN_PAR_LSB +: DCSR_WIDTH];

   // Previous clock levels; reset low so release never fakes an edge
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         shift_clk_prev_q <= 1'b0;
         load_clk_prev_q <= 1'b0;
      end else begin
         shift_clk_prev_q <= sync2_q[DCSR_PIN_SHIFT_CLK];
         load_clk_prev_q <= sync2_q[DCSR_PIN_LOAD_CLK];
      end
   end

   // High-to-low detection only; rising edges produce nothing
   assign shift_fall = shift_clk_prev_q && !sync2_q[DCSR_PIN_SHIFT_CLK];
   assign load_fall = load_clk_prev_q && !sync2_q[DCSR_PIN_LOAD_CLK];

   // Effective mode follows the synchronised select level
   assign mode_eff = mode_s ? DCSR_MODE_LOAD : DCSR_MODE_SHIFT;

   // Next register value per mode; the unselected clock is ignored
   always_comb begin
      reg_d = reg_q;
      upd = 1'b0;
      case (mode_eff)
         DCSR_MODE_SHIFT: begin
            if (shift_fall) begin
               upd = 1'b1;
               reg_d = {reg_q[DCSR_WIDTH-2:0], serial_s};
            end
         end
         DCSR_MODE_LOAD: begin
            if (load_fall) begin
               upd = 1'b1;
               reg_d = par_s;
            end
         end
         default: begin
            upd = 1'b0;
            reg_d = reg_q;
         end
      endcase
   end

   // The register itself; a mode change alone leaves it untouched
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         reg_q <= DCSR_REG_RESET;
      end else if (upd) begin
         reg_q <= reg_d;
      end
   end

   // Update and overflow pulses, raised in the same cycle the register shows its new value
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         upd_q <= 1'b0;
         ovf_q <= 1'b0;
      end else begin
         upd_q <= upd;
         ovf_q <= upd && !fifo_ready;
      end
   end

   // Outputs straight from registers
   assign o_reg_out = reg_q;
   assign o_mode_load = mode_s;
   assign o_update = upd_q;
   assign o_overflow = ovf_q;

   // Every new value is pushed; a full queue drops it and flags overflow
   dcsr_fifo #(
      .WIDTH(DCSR_WIDTH),
      .DEPTH(DCSR_FIFO_DEPTH)
   ) u_fifo (
      .i_clk(i_clk),
      .i_reset(i_reset),
      .i_wr_valid(upd),
      .o_wr_ready(fifo_ready),
      .i_wr_data(reg_d),
      .o_rd_valid(o_stream_valid),
      .i_rd_ready(i_stream_ready),
      .o_rd_data(o_stream_data)
   );

   // Checks on the register and stream queue behaviour
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_reset);

   property p_unselected;
      (shift_fall && mode_s && !load_fall) or (load_fall && !mode_s && !shift_fall)
         |=> $stable(reg_q);
   endproperty

   // A falling edge of the clock that the mode does not enable is ignored
   unsel_clock_a: assert property (p_unselected)
      else $error("Unselected clock changed the register");

   // Rising clock edges never move the register
   rise_none_a: assert property (
      ($rose(sync2_q[DCSR_PIN_SHIFT_CLK]) || $rose(sync2_q[DCSR_PIN_LOAD_CLK]))
         && !shift_fall && !load_fall |=> $stable(reg_q))
      else $error("Rising clock edge changed the register");

   // Load copies the parallel word and pulses the update flag
   load_copy_a: assert property (
      load_fall && mode_s |=> reg_q == $past(par_s) && o_update)
      else $error("Parallel load did not copy inputs");

   // Shift moves every bit one place up and takes the serial bit in
   shift_move_a: assert property (
      shift_fall && !mode_s |=> reg_q == {$past(reg_q[2:0]), $past(serial_s)})
      else $error("Shift did not move bits right");

   // A mode change on its own leaves the register alone
   mode_change_a: assert property (
      $changed(mode_s) && !shift_fall && !load_fall |=> $stable(reg_q))
      else $error("Mode change alone altered the register");

   // Mode rising while the load clock is high leaves the register alone
   mode_rise_a: assert property (
      $rose(mode_s) && sync2_q[DCSR_PIN_LOAD_CLK] |=> $stable(reg_q))
      else $error("Mode rise under high load clock altered the register");

   // Without an enabled falling edge the register holds
   hold_idle_a: assert property (
      !(shift_fall && !mode_s) && !(load_fall && mode_s) |=> $stable(reg_q) && !o_update)
      else $error("Register changed without an enabled edge");

   // Serial pin reaches bit 0 three cycles after it is sampled
   pin_to_reg_a: assert property (
      !mode_s && shift_fall |=> reg_q[0] == $past(i_serial_in, 3))
      else $error("Serial pin did not reach bit 0");

   // An update needs a falling edge of the clock that the mode enables
   upd_source_a: assert property (
      upd |-> (shift_fall && !mode_s) || (load_fall && mode_s))
      else $error("Update without an enabled falling edge");

   // Enabled falling edges are spaced, so update pulses never run together
   update_pulse_a: assert property (
      o_update |=> !o_update)
      else $error("Update pulse lasted more than one cycle");

   // Every accepted update shows up at the stream output
   queue_push_a: assert property (
      upd && fifo_ready |-> ##[1:18] o_stream_valid)
      else $error("Update never reached the stream output");

   // Overflow can only mark an update that the queue refused
   overflow_upd_a: assert property (
      o_overflow |-> o_update)
      else $error("Overflow flagged without an update");

   // A stream word waiting for the reader stays put
   stream_hold_a: assert property (
      o_stream_valid && !i_stream_ready |=> o_stream_valid && $stable(o_stream_data))
      else $error("Stream word changed before it was taken");

   // Scenarios worth seeing in a run
   shift_seen_c: cover property (shift_fall && !mode_s ##[1:40] shift_fall && !mode_s);
   load_seen_c: cover property (load_fall && mode_s);
   mode_swap_c: cover property ($changed(mode_s) ##[1:40] upd);
   overflow_c: cover property (o_overflow);

endmodule
